// *** hw/psa_host_end.sv ***
// host end: apb register slave driving the converter link as a mode 1 serial master
// assumes the converter samples the link with its own clock; serial clock made here
//
// Overview of operation
// RULE_01 - reset opcode restores configuration defaults
// RULE_02 - host initialises registers before using samples
// RULE_03 - memory select high, then converter select low
// RULE_04 - one write of four default bytes
// RULE_05 - reset opcode precedes default register write
// RULE_06 - host captures temperature and pressure samples
// RULE_07 - converter select low before each sequence
// RULE_08 - temperature mode: write register 1, select set
// RULE_09 - pressure mode: write register 1, select clear
// RULE_10 - start opcode begins a conversion
// RULE_11 - sample shifts out after command byte
// RULE_12 - temperature read: 14 result bits, 10 discarded
// RULE_13 - temperature code is two's complement
// RULE_14 - host scales temperature by 0.03125 per count; the host returns the raw 14-bit code, zero-extended and unscaled
// RULE_15 - pressure is 24-bit two's complement, msb first
// RULE_16 - pressure code saturates at full scale
// RULE_17 - never both selects low together
// RULE_18 - link uses spi mode 1
// RULE_19 - write opcode 0100, register, count minus one
// RULE_20 - register 1 layout; bit 2 one, bit 0 zero
`timescale 1ns/1ps
`include "psa_consts.svh"
module psa_host_end #(
    parameter int HALF = `PSA_SCLK_HALF_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    psa_link_if.host         link
);
    psa_pkg::psa_host_state_e state;
    psa_pkg::psa_kind_e       kind;
    psa_pkg::psa_kind_e       req_kind;
    logic [7:0]  div_cnt;
    logic [5:0]  bit_cnt;
    logic [47:0] tx_sr;
    logic [23:0] rx_sr;
    logic [1:0]  miso_sync;
    logic        sclk_reg;
    logic        sel_n_reg;
    logic        mem_sel_n_reg;
    logic        mosi_reg;
    logic        frame_done;
    logic        req;
    logic [2:0]  cfg_rate;
    logic [1:0]  cfg_mode;
    logic [31:0] defaults_reg;
    logic [13:0] temp_reg;
    logic [23:0] press_reg;
    logic        temp_val;
    logic        press_val;
    logic        init_done;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        wr_now;
    logic        mapped;
    logic        half_up;
    logic        st_clear;

    assign half_up  = (div_cnt == 8'(HALF - 1));
    assign wr_now   = psel & penable & pready_reg & pwrite;
    assign mapped   = (paddr == `PSA_OFF_CTRL) | (paddr == `PSA_OFF_CFG) |
                      (paddr == `PSA_OFF_DEFAULTS) | (paddr == `PSA_OFF_STATUS) |
                      (paddr == `PSA_OFF_TEMP) | (paddr == `PSA_OFF_PRESS);
    assign st_clear = wr_now & (paddr == `PSA_OFF_STATUS);

    // temperature and pressure requests are ignored until the defaults are loaded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req      <= 1'b0;
            req_kind <= psa_pkg::PSA_KIND_INIT;
        end else begin
            req <= 1'b0;
            if (wr_now && paddr == `PSA_OFF_CTRL && state == psa_pkg::PSA_H_IDLE && !req) begin
                if (pwdata[`PSA_CTRL_INIT]) begin
                    req      <= 1'b1;
                    req_kind <= psa_pkg::PSA_KIND_INIT;
                end else if (pwdata[`PSA_CTRL_TEMP] && init_done) begin // [RULE_02]
                    req      <= 1'b1;
                    req_kind <= psa_pkg::PSA_KIND_TEMP;
                end else if (pwdata[`PSA_CTRL_PRESS] && init_done) begin // [RULE_02]
                    req      <= 1'b1;
                    req_kind <= psa_pkg::PSA_KIND_PRESS;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            miso_sync <= 2'h0;
        else
            miso_sync <= {miso_sync[0], link.miso};
    end

    // frame engine: select low, 48 clocks, select high, one idle half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= psa_pkg::PSA_H_IDLE;
            kind          <= psa_pkg::PSA_KIND_INIT;
            div_cnt       <= 8'h00;
            bit_cnt       <= 6'h00;
            tx_sr         <= 48'h0;
            rx_sr         <= 24'h0;
            sclk_reg      <= 1'b0;
            sel_n_reg     <= 1'b1;
            mem_sel_n_reg <= 1'b1;
            mosi_reg      <= 1'b0;
            frame_done    <= 1'b0;
        end else begin
            frame_done    <= 1'b0;
            mem_sel_n_reg <= 1'b1; // [RULE_03] [RULE_17]
            unique case (state)
                psa_pkg::PSA_H_IDLE: begin
                    div_cnt <= 8'h00;
                    bit_cnt <= 6'h00;
                    if (req) begin
                        kind      <= req_kind;
                        sel_n_reg <= 1'b0; // [RULE_03] [RULE_07]
                        state     <= psa_pkg::PSA_H_LEAD;
                        if (req_kind == psa_pkg::PSA_KIND_INIT)
                            tx_sr <= {`PSA_OP_RESET, `PSA_REGISTER_WRITE_OPCODE_ALL, // [RULE_05] [RULE_04]
                                      defaults_reg[7:0], defaults_reg[15:8],
                                      defaults_reg[23:16], defaults_reg[31:24]};
                        else
                            tx_sr <= {`PSA_REGISTER_WRITE_OPCODE_CFG1, // [RULE_08] [RULE_09]
                                      psa_pkg::psa_cfg1(cfg_rate, cfg_mode, // [RULE_20]
                                          req_kind == psa_pkg::PSA_KIND_TEMP),
                                      `PSA_OP_START, `PSA_OP_NOP, // [RULE_10]
                                      `PSA_OP_NOP, `PSA_OP_NOP};
                    end
                end
                psa_pkg::PSA_H_LEAD: begin
                    div_cnt <= half_up ? 8'h00 : div_cnt + 8'h01;
                    if (half_up) begin
                        sclk_reg <= 1'b1;
                        mosi_reg <= tx_sr[`PSA_FRAME_BITS-1];
                        tx_sr    <= {tx_sr[46:0], 1'b0};
                        state    <= psa_pkg::PSA_H_SHIFT;
                    end
                end
                psa_pkg::PSA_H_SHIFT: begin
                    div_cnt <= half_up ? 8'h00 : div_cnt + 8'h01;
                    if (half_up && sclk_reg) begin
                        sclk_reg <= 1'b0;
                        rx_sr    <= {rx_sr[22:0], miso_sync[1]}; // [RULE_18]
                        bit_cnt  <= bit_cnt + 6'h01;
                        if (bit_cnt == 6'(`PSA_FRAME_BITS - 1))
                            state <= psa_pkg::PSA_H_TAIL;
                    end else if (half_up) begin
                        sclk_reg <= 1'b1; // [RULE_18]
                        mosi_reg <= tx_sr[`PSA_FRAME_BITS-1];
                        tx_sr    <= {tx_sr[46:0], 1'b0};
                    end
                end
                psa_pkg::PSA_H_TAIL: begin
                    div_cnt <= half_up ? 8'h00 : div_cnt + 8'h01;
                    if (half_up) begin
                        sel_n_reg <= 1'b1;
                        mosi_reg  <= 1'b0;
                        state     <= psa_pkg::PSA_H_GAP;
                    end
                end
                psa_pkg::PSA_H_GAP: begin
                    div_cnt <= half_up ? 8'h00 : div_cnt + 8'h01;
                    if (half_up) begin
                        frame_done <= 1'b1;
                        state      <= psa_pkg::PSA_H_IDLE;
                    end
                end
            endcase
        end
    end

    // results; a new sample sets its flag even in the cycle software clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_reg  <= 14'h0000;
            press_reg <= 24'h000000;
            temp_val  <= 1'b0;
            press_val <= 1'b0;
            init_done <= 1'b0;
        end else begin
            if (st_clear && pwdata[`PSA_ST_TEMP_VAL])
                temp_val <= 1'b0;
            if (st_clear && pwdata[`PSA_ST_PRESS_VAL])
                press_val <= 1'b0;
            if (frame_done) begin
                unique case (kind)
                    psa_pkg::PSA_KIND_INIT: init_done <= 1'b1;
                    psa_pkg::PSA_KIND_TEMP: begin
                        temp_reg <= rx_sr[`PSA_SAMPLE_BITS-1:`PSA_FILL_BITS]; // [RULE_12] [RULE_06]
                        temp_val <= 1'b1;
                    end
                    psa_pkg::PSA_KIND_PRESS: begin
                        press_reg <= rx_sr; // [RULE_15] [RULE_06]
                        press_val <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_rate     <= 3'h0;
            cfg_mode     <= 2'h0;
            defaults_reg <= `PSA_CFG_DEFAULT;
        end else if (wr_now && paddr == `PSA_OFF_CFG) begin
            cfg_rate <= pwdata[7:5];
            cfg_mode <= pwdata[4:3];
        end else if (wr_now && paddr == `PSA_OFF_DEFAULTS) begin
            defaults_reg <= pwdata;
        end
    end

    // one wait state: read data latched in setup, ready raised in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel & penable & ~pready_reg;
            pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
            if (psel && !penable) begin
                unique case (paddr)
                    `PSA_OFF_CFG:      prdata_reg <= {24'h0, cfg_rate, cfg_mode, 3'h0};
                    `PSA_OFF_DEFAULTS: prdata_reg <= defaults_reg;
                    `PSA_OFF_STATUS:   prdata_reg <= {28'h0, init_done, press_val, temp_val,
                                                      state != psa_pkg::PSA_H_IDLE || req};
                    `PSA_OFF_TEMP:     prdata_reg <= {18'h0, temp_reg}; // [RULE_13] [RULE_14]
                    `PSA_OFF_PRESS:    prdata_reg <= {8'h0, press_reg}; // [RULE_16]
                    default:           prdata_reg <= 32'h0;
                endcase
            end
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign link.sclk            = sclk_reg;
    assign link.adc_select_n    = sel_n_reg;
    assign link.memory_select_n = mem_sel_n_reg;
    assign link.mosi            = mosi_reg;
endmodule // psa_host_end

// *** hw/psa_consts.svh ***
// constants shared by both ends of the converter link and the host register map
// assumes inclusion by bare name from design files under hw/
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH

`define PSA_OP_RESET      8'h06
`define PSA_OP_START      8'h08
`define PSA_OP_NOP        8'h00
`define PSA_REGISTER_WRITE_OPCODE_NIBBLE   4'h4
`define PSA_REGISTER_WRITE_OPCODE_ALL      8'h43
`define PSA_REGISTER_WRITE_OPCODE_CFG1     8'h44
`define PSA_CFG1_INDEX    2'h1
`define PSA_TEMP_SEL_POS  1
`define PSA_CFG1_ONE_POS  2
`define PSA_TEMP_BITS     14
`define PSA_FILL_BITS     10
`define PSA_SAMPLE_BITS   24
`define PSA_FRAME_BITS    48
`define PSA_POS_FULL      24'h7fffff
`define PSA_NEG_FULL      24'h800000
`define PSA_LFSR_SEED     16'hace1
`define PSA_CFG_DEFAULT   32'h0000_0000

`define PSA_PCLK_NS       40
`define PSA_SCLK_HALF_NS  320
`define PSA_SCLK_HALF_CYC ((`PSA_SCLK_HALF_NS + `PSA_PCLK_NS - 1) / `PSA_PCLK_NS)

`define PSA_OFF_CTRL      12'h000
`define PSA_OFF_CFG       12'h004
`define PSA_OFF_DEFAULTS  12'h008
`define PSA_OFF_STATUS    12'h00c
`define PSA_OFF_TEMP      12'h010
`define PSA_OFF_PRESS     12'h014

`define PSA_CTRL_INIT     0
`define PSA_CTRL_TEMP     1
`define PSA_CTRL_PRESS    2
`define PSA_ST_BUSY       0
`define PSA_ST_TEMP_VAL   1
`define PSA_ST_PRESS_VAL  2
`define PSA_ST_INIT_DONE  3

`endif

// *** hw/psa_pkg.sv ***
// types and small helpers used by the host end
// assumes psa_consts.svh is on the include path
`include "psa_consts.svh"
package psa_pkg;
    typedef enum logic [2:0] {
        PSA_H_IDLE,
        PSA_H_LEAD,
        PSA_H_SHIFT,
        PSA_H_TAIL,
        PSA_H_GAP
    } psa_host_state_e;

    typedef enum logic [1:0] {
        PSA_KIND_INIT,
        PSA_KIND_TEMP,
        PSA_KIND_PRESS
    } psa_kind_e;

    // configuration register 1 image: rate, mode, fixed one, temperature select, fixed zero
    function automatic logic [7:0] psa_cfg1(input logic [2:0] rate_field,
                                            input logic [1:0] mode,
                                            input logic       temperature_select_bit);
        psa_cfg1 = {rate_field, mode, 1'b1, temperature_select_bit, 1'b0};
    endfunction
endpackage

// *** hw/psa_link_if.sv ***
// serial link between host controller and converter: clock, two selects, data both ways
// assumes both ends run on their own pclk and sample these wires through synchronisers
`timescale 1ns/1ps
interface psa_link_if;
    logic sclk;
    logic adc_select_n;
    logic memory_select_n;
    logic mosi;
    logic miso;

    modport host (
        output sclk,
        output adc_select_n,
        output memory_select_n,
        output mosi,
        input  miso
    );

    modport adc (
        input  sclk,
        input  adc_select_n,
        input  memory_select_n,
        input  mosi,
        output miso
    );
endinterface

// *** hw/psa_adc_end.sv ***
// converter end: command decoder, configuration registers and sample shifter
// assumes the link wires are asynchronous to pclk and the serial clock is slow enough
// for two-flop sampling (at least four pclk cycles per half period)
`timescale 1ns/1ps
`include "psa_consts.svh"
module psa_adc_end #(
    parameter int          PW          = 32,
    parameter logic [31:0] CFG_DEFAULT = `PSA_CFG_DEFAULT
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    psa_link_if.adc                   link,
    input  wire logic [13:0]          temp_code,
    input  wire logic signed [PW-1:0] press_level,
    output logic [31:0]               cfg_out,
    output logic                      conv_start,
    output logic                      temp_mode
);
    logic [2:0]       sclk_sync;
    logic [1:0]       sel_sync;
    logic [1:0]       mosi_sync;
    logic [2:0]       bit_cnt;
    logic [7:0]       in_sr;
    logic [23:0]      out_sr;
    logic             miso_reg;
    logic [3:0][7:0]  cfg_reg;
    logic [2:0]       wr_left;
    logic [1:0]       wr_ptr;
    logic [15:0]      lfsr;
    logic             conv_start_reg;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             selected;
    logic             byte_done;
    logic [7:0]       rx_byte;

    // saturating pressure code, one count per full scale over two to the 23rd
    function automatic logic [23:0] psa_sat24(input logic signed [PW-1:0] v);
        if (v >= PW'(signed'({1'b0, `PSA_POS_FULL})))
            psa_sat24 = `PSA_POS_FULL; // [RULE_16]
        else if (v <= -PW'(signed'({1'b0, `PSA_NEG_FULL})))
            psa_sat24 = `PSA_NEG_FULL; // [RULE_16]
        else
            psa_sat24 = v[23:0];
    endfunction

    // second flop of each pair is the only reader of the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_sync <= 3'h0;
            sel_sync  <= 2'h3;
            mosi_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], link.sclk};
            sel_sync  <= {sel_sync[0], link.adc_select_n};
            mosi_sync <= {mosi_sync[0], link.mosi};
        end
    end

    // mode 1: data out on rising, data in on falling [RULE_18]
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign selected  = ~sel_sync[1];
    assign byte_done = selected & sclk_fall & (bit_cnt == 3'h7);
    assign rx_byte   = {in_sr[6:0], mosi_sync[1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 3'h0;
            in_sr   <= 8'h00;
        end else if (!selected) begin
            bit_cnt <= 3'h0;
        end else if (sclk_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            in_sr   <= rx_byte;
        end
    end

    // commands are decoded on every byte boundary except the data bytes of a register write, also while a sample shifts out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_DEFAULT;
            wr_left <= 3'h0;
            wr_ptr  <= 2'h0;
        end else if (!selected) begin
            wr_left <= 3'h0;
        end else if (byte_done) begin
            if (wr_left != 3'h0) begin
                cfg_reg[wr_ptr] <= rx_byte;
                wr_ptr          <= wr_ptr + 2'h1;
                wr_left         <= wr_left - 3'h1;
            end else if (rx_byte == `PSA_OP_RESET) begin
                cfg_reg <= CFG_DEFAULT; // [RULE_01]
            end else if (rx_byte[7:4] == `PSA_REGISTER_WRITE_OPCODE_NIBBLE) begin
                wr_ptr  <= rx_byte[3:2]; // [RULE_19]
                wr_left <= 3'({1'b0, rx_byte[1:0]}) + 3'h1; // [RULE_19]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lfsr <= `PSA_LFSR_SEED;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    // sample is captured at the start byte and leaves msb first on the next rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_sr         <= 24'h000000;
            miso_reg       <= 1'b0;
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            if (!selected) begin
                out_sr   <= 24'h000000;
                miso_reg <= 1'b0;
            end else if (byte_done && wr_left == 3'h0 && rx_byte == `PSA_OP_START) begin
                conv_start_reg <= 1'b1; // [RULE_10]
                if (cfg_reg[`PSA_CFG1_INDEX][`PSA_TEMP_SEL_POS])
                    out_sr <= {temp_code, lfsr[`PSA_FILL_BITS-1:0]}; // [RULE_12] [RULE_13]
                else
                    out_sr <= psa_sat24(press_level); // [RULE_15]
            end else if (sclk_rise) begin
                miso_reg <= out_sr[`PSA_SAMPLE_BITS-1]; // [RULE_11]
                out_sr   <= {out_sr[22:0], 1'b0};
            end
        end
    end

    assign link.miso  = miso_reg;
    assign cfg_out    = cfg_reg;
    assign conv_start = conv_start_reg;
    assign temp_mode  = cfg_reg[`PSA_CFG1_INDEX][`PSA_TEMP_SEL_POS];
endmodule // psa_adc_end

// *** tb/psa_link_props.sv ***
// link checker: mode 1 timing, frame length and command order on the wires
// assumes the interface signals as plain inputs and the host's default half period
`timescale 1ns/1ps
`include "psa_consts.svh"
module psa_link_props #(
    parameter int HALF = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic adc_select_n,
    input wire logic memory_select_n,
    input wire logic mosi,
    input wire logic miso
);
    logic        sclk_q;
    logic [7:0]  hi_cnt;
    logic [6:0]  rise_cnt;
    logic [47:0] frame;
    wire         rise = sclk && !sclk_q && !adc_select_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            hi_cnt <= 8'h00;
        end else begin
            sclk_q <= sclk;
            hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
        end
    end
    // mosi and sclk leave the host on the same edge, so the bit is taken at the rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt <= 7'h00;
            frame    <= 48'h0;
        end else if (adc_select_n) begin
            rise_cnt <= 7'h00;
        end else if (rise) begin
            rise_cnt <= rise_cnt + 7'h01;
            frame    <= {frame[46:0], mosi};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_mem_idle; memory_select_n; endproperty
    property p_sclk_idle; adc_select_n |-> !sclk; endproperty
    property p_lead; $fell(adc_select_n) |-> !sclk [*6]; endproperty
    property p_hi_len; $fell(sclk) |-> hi_cnt == HALF; endproperty
    property p_mosi_hold; sclk && sclk_q |-> $stable(mosi); endproperty
    property p_miso_edge; !adc_select_n && $changed(miso) |-> sclk; endproperty
    property p_len; $rose(adc_select_n) |-> rise_cnt == 7'h30; endproperty
    property p_first;
        $rose(adc_select_n) |-> frame[47:40] == `PSA_OP_RESET || frame[47:40] == `PSA_REGISTER_WRITE_OPCODE_CFG1;
    endproperty
    property p_init;
        $rose(adc_select_n) && frame[47:40] == `PSA_OP_RESET |-> frame[39:32] == `PSA_REGISTER_WRITE_OPCODE_ALL;
    endproperty
    property p_read;
        $rose(adc_select_n) && frame[47:40] == `PSA_REGISTER_WRITE_OPCODE_CFG1
            |-> frame[34] && !frame[32] && frame[31:24] == `PSA_OP_START;
    endproperty
    a_mem_idle: assert property (p_mem_idle)
        else $error("memory select went low");
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock high while deselected");
    a_lead: assert property (p_lead)
        else $error("serial clock rose too soon after select");
    a_hi_len: assert property (p_hi_len)
        else $error("serial clock high phase has wrong length");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("host data moved while clock high");
    a_miso_edge: assert property (p_miso_edge)
        else $error("converter data moved while clock low");
    a_len: assert property (p_len)
        else $error("frame is not 48 clock pulses");
    a_first: assert property (p_first)
        else $error("frame opens with an unexpected byte");
    a_init: assert property (p_init)
        else $error("reset byte not followed by full register write");
    a_read: assert property (p_read)
        else $error("read frame layout wrong");
    c_init: cover property ($rose(adc_select_n) && frame[47:40] == `PSA_OP_RESET);
    c_temp: cover property ($rose(adc_select_n) && frame[47:40] == `PSA_REGISTER_WRITE_OPCODE_CFG1 && frame[33]);
    c_press: cover property ($rose(adc_select_n) && frame[47:40] == `PSA_REGISTER_WRITE_OPCODE_CFG1 && !frame[33]);
endmodule // psa_link_props

// *** tb/tb_pressure_adc_spi_sequencer.sv ***
// bench: host end and converter end joined by the link, driven over apb
// assumes the designer's register map and the default serial half period
`timescale 1ns/1ps
`include "psa_consts.svh"
module tb_pressure_adc_spi_sequencer;
    localparam int          HALF = `PSA_SCLK_HALF_CYC;
    localparam logic [31:0] CFGD = 32'h1122_3344;
    localparam logic [31:0] DEFS = 32'h0040_840a;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic               conv_start, temp_mode, rerr, armed;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, cfg_out, rdata, cfg_q, first_chg, conv_n;
    logic [13:0]        temp_code;
    logic signed [31:0] press_level;
    int                 bad_count, n_tests;
    logic [31:0] lv [6] = '{32'h5, 32'hffff_ffff, 32'h7f_ffff, 32'h90_0000,
                            32'hff80_0000, 32'hff70_0000};
    logic [31:0] ex [6] = '{32'h5, 32'hff_ffff, 32'h7f_ffff, 32'h7f_ffff,
                            32'h80_0000, 32'h80_0000};
    psa_link_if link();
    psa_host_end #(.HALF(HALF)) u_psa_host_end (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    psa_adc_end #(.CFG_DEFAULT(CFGD)) u_psa_adc_end (.pclk(pclk), .presetn(presetn),
        .link(link), .temp_code(temp_code), .press_level(press_level), .cfg_out(cfg_out),
        .conv_start(conv_start), .temp_mode(temp_mode));
    psa_link_props #(.HALF(HALF)) u_psa_link_props (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .adc_select_n(link.adc_select_n),
        .memory_select_n(link.memory_select_n), .mosi(link.mosi), .miso(link.miso));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // first configuration change of a frame shows whether the reset byte acted
    always @(posedge pclk) begin
        cfg_q <= cfg_out;
        if (!presetn)
            conv_n <= 32'h0;
        else if (conv_start === 1'b1)
            conv_n <= conv_n + 32'h1;
        if (armed && cfg_out !== cfg_q) begin
            first_chg <= cfg_out;
            armed     <= 1'b0;
        end
    end
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            bad_count++;
            finish_test();
        end
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    // busy must be clear too, otherwise a stale flag ends the wait early
    task wait_st(input int b);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, `PSA_OFF_STATUS, 32'h0);
            if (rdata[b] === 1'b1 && rdata[0] === 1'b0)
                break;
        end
        if (i == 400) begin
            bad_count++;
            finish_test();
        end
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {armed, press_level} = '0;
        temp_code = 14'h3ce0;
        bad_count = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(cfg_out, CFGD);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
        apb(1'b1, `PSA_OFF_CTRL, 32'h2);
        repeat (4) @(posedge pclk);
        rd(`PSA_OFF_STATUS, 32'h0);
        apb(1'b1, `PSA_OFF_DEFAULTS, DEFS);
        rd(`PSA_OFF_DEFAULTS, DEFS);
        apb(1'b1, `PSA_OFF_CTRL, 32'h1);
        wait_st(`PSA_ST_INIT_DONE);
        chk(cfg_out, DEFS);
        apb(1'b1, `PSA_OFF_CFG, 32'ha0);
        rd(`PSA_OFF_CFG, 32'ha0);
        apb(1'b1, `PSA_OFF_CTRL, 32'h2);
        wait_st(`PSA_ST_TEMP_VAL);
        rd(`PSA_OFF_TEMP, 32'h3ce0);
        // one count is a thirty-second of a degree: this code is minus 25 degrees
        chk(32'($signed(rdata[13:0]) / 32), 32'hffff_ffe7);
        chk(cfg_out, {DEFS[31:16], 8'ha6, DEFS[7:0]});
        chk({31'h0, temp_mode}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, `PSA_OFF_STATUS, 32'h6);
            press_level <= lv[k];
            apb(1'b1, `PSA_OFF_CTRL, 32'h4);
            if (k == 0)
                apb(1'b1, `PSA_OFF_CTRL, 32'h2);
            wait_st(`PSA_ST_PRESS_VAL);
            rd(`PSA_OFF_PRESS, ex[k]);
        end
        chk(cfg_out, {DEFS[31:16], 8'ha4, DEFS[7:0]});
        chk({31'h0, temp_mode}, 32'h0);
        chk(conv_n, 32'h7);
        apb(1'b1, `PSA_OFF_STATUS, 32'h6);
        rd(`PSA_OFF_STATUS, 32'h8);
        armed <= 1'b1;
        apb(1'b1, `PSA_OFF_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        wait_st(`PSA_ST_INIT_DONE);
        chk(first_chg, CFGD);
        chk(cfg_out, DEFS);
        finish_test();
    end
endmodule // tb_pressure_adc_spi_sequencer
